// [rtl/ccmv_pkg.sv]
// Purpose: Shared constants and types for the call-mode and vector block
// Assumes: 14-bit program addresses, 8-bit program-memory bytes
// Notes: Vector byte 0 carries the bank-enable flags and the upper address bits
package ccmv_pkg;
    // Mode register
    localparam int MODE_REG_W = 4;
    localparam int MODE_SEL_BIT = 3;
    localparam logic [3:0] MODE_REG_RESET = 4'h8;
    // Program-memory layout
    localparam int ADDR_W = 14;
    localparam logic [13:0] RESET_VEC = 14'h0000;
    localparam logic [13:0] RESET_VEC_LAST = 14'h0001;
    localparam logic [13:0] IRQ_VEC_BASE = 14'h0002;
    localparam logic [13:0] IRQ_VEC_LAST = 14'h000d;
    localparam logic [13:0] TABLE_BASE = 14'h0020;
    localparam logic [13:0] TABLE_LAST = 14'h007f;
    localparam logic [2:0] IRQ_COUNT = 3'h6;
    localparam logic [5:0] TABLE_COUNT = 6'h30;
    // Vector byte 0 field positions
    localparam int VEC_MEM_BANK_BIT = 7;
    localparam int VEC_REG_BANK_BIT = 6;
    // Stack bytes per call
    localparam logic [1:0] PUSH_LEGACY = 2'h2;
    localparam logic [1:0] PUSH_EXT = 2'h3;
    // Machine cycles per instruction
    localparam logic [2:0] CYC_LONG_LEGACY = 3'h3;
    localparam logic [2:0] CYC_LONG_EXT = 3'h4;
    localparam logic [2:0] CYC_FAST_LEGACY = 3'h2;
    localparam logic [2:0] CYC_FAST_EXT = 3'h3;
    localparam logic [2:0] CYC_FAR = 3'h3;
    localparam logic [2:0] CYC_OTHER = 3'h1;

    typedef enum logic [2:0] {OP_OTHER, OP_CALL_LONG, OP_CALL_FAST, OP_FAR_BR, OP_FAR_CALL}
        ccmv_op_e;
    typedef enum logic [1:0] {FK_RESET, FK_IRQ, FK_TABLE} ccmv_fetch_e;
endpackage

// [rtl/ccmv_fetch_if.sv]
// Purpose: Carries fetch requests between sequencer and address generator
// Assumes: One clock domain
// Notes: load starts a two-byte fetch, step moves to the second byte
`timescale 1ns/1ps
interface ccmv_fetch_if;
    import ccmv_pkg::*;
    ccmv_fetch_e kind;
    logic [5:0] idx;
    logic load;
    logic step;
    logic [13:0] addr;
    modport gen (input kind, input idx, input load, input step, output addr);
    modport ctl (output kind, output idx, output load, output step, input addr);
endinterface // ccmv_fetch_if

// [rtl/ccmv_addr_gen.sv]
// Purpose: Program-memory address generator for vectors and table entries
// Assumes: Index ranges are limited by the sequencer
// Notes: Each entry is two bytes, so the index is doubled
`timescale 1ns/1ps
module ccmv_addr_gen
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    ccmv_fetch_if.gen fIf
);
    import ccmv_pkg::*;

    logic [13:0] addr_r;
    logic [13:0] baseAddr;
    logic [13:0] irqOff;
    logic [13:0] tblOff;

    // Entry base from fetch kind
    assign irqOff = {7'h00, fIf.idx, 1'b0};
    assign tblOff = {7'h00, fIf.idx, 1'b0};
    assign baseAddr = (fIf.kind == FK_IRQ) ? IRQ_VEC_BASE + irqOff :
                      (fIf.kind == FK_TABLE) ? TABLE_BASE + tblOff : RESET_VEC;
    assign fIf.addr = addr_r;

    // Address register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            addr_r <= 14'h0000;
        else if (clkEn && fIf.load)
            addr_r <= baseAddr;
        else if (clkEn && fIf.step)
            addr_r <= addr_r + 14'h0001;
    end

    a_irq_vec_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && fIf.load && fIf.kind == FK_IRQ |=> addr_r >= IRQ_VEC_BASE && addr_r < IRQ_VEC_LAST)
        else $error("interrupt vector outside its window");
    a_table_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && fIf.load && fIf.kind == FK_TABLE |=> addr_r >= TABLE_BASE && addr_r < TABLE_LAST)
        else $error("table fetch outside table area");
    a_reset_vec_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && fIf.load && fIf.kind == FK_RESET |=> addr_r == RESET_VEC)
        else $error("reset vector not at address zero");
endmodule // ccmv_addr_gen

// [rtl/ccmv_core.sv]
// Purpose: Call-mode select, call timing and vector/table fetch sequencing
// Assumes: Requests and pins synchronous to sys_clk; ROM data valid with romAddr
// Notes: Mode is latched when an instruction is accepted
//
// Behaviour
// - Mode register bit 3 selects call mode
// - Calls push two or three stack bytes
// - Far branch and call need extended mode
// - Long call takes three or four cycles
// - Fast call takes two or three cycles
// - Reset sets mode bit, legacy mode
// - Mode register written whole, four bits
// - Reset fetches start vector at 0000H/0001H
// - Interrupts fetch vectors from 0002H-000DH
// - Table execute reads entries 0020H-007FH
// - One-byte table execute replaces longer instruction
// - System reset is active low
// - Sub-oscillator pin readable as test bit
`timescale 1ns/1ps
module ccmv_core
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic modeWrEn,
    input wire logic [3:0] modeWrData,
    output logic [3:0] modeRdData,
    output logic legacyMode,
    input wire logic subOscIn,
    output logic subOscTestBit,
    input wire logic opValid,
    input wire ccmv_pkg::ccmv_op_e opKind,
    output logic opReady,
    output logic opFault,
    output logic [1:0] pushBytes,
    output logic [2:0] opCycles,
    output logic opBusy,
    output logic opDone,
    input wire logic irqReq,
    input wire logic [2:0] irqIdx,
    input wire logic tblReq,
    input wire logic [5:0] tblIdx,
    output logic [13:0] romAddr,
    input wire logic [7:0] romData,
    output logic vecValid,
    output logic [13:0] startPc,
    output logic regBankEnFlag,
    output logic memBankEnFlag,
    output logic tableValid,
    output logic [15:0] tableEntry
);
    import ccmv_pkg::*;

    typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_FETCH0, ST_FETCH1, ST_EXEC} ccmv_state_e;

    ccmv_fetch_if fIf ();
    ccmv_state_e state_r;
    ccmv_state_e state_nxt;
    ccmv_fetch_e kind_r;
    logic [5:0] idx_r;
    logic [3:0] modeReg_r;
    logic [7:0] byte0_r;
    logic [2:0] cnt_r;
    logic [1:0] push_r;
    logic [2:0] cyc_r;
    logic fault_r;
    logic subOsc_r;
    logic vecValid_r;
    logic [13:0] startPc_r;
    logic regBankEn_r;
    logic memBankEn_r;
    logic tblValid_r;
    logic [15:0] tblEntry_r;
    logic modeLegacy;
    logic irqTake;
    logic tblTake;
    logic opTake;
    logic farOp;
    logic [2:0] opCycSel;
    logic [1:0] opPushSel;

    ccmv_addr_gen u_addr_gen
    (
        .sys_clk (sys_clk),
        .rst_n (rst_n),
        .clkEn (clkEn),
        .fIf (fIf)
    );

    assign modeLegacy = modeReg_r[MODE_SEL_BIT];

    // Request arbitration, interrupt before table before instruction
    assign irqTake = (state_r == ST_IDLE) && irqReq && (irqIdx < IRQ_COUNT);
    assign tblTake = (state_r == ST_IDLE) && !irqTake && tblReq && (tblIdx < TABLE_COUNT);
    assign opTake = (state_r == ST_IDLE) && !irqReq && !tblReq && opValid;
    assign farOp = (opKind == OP_FAR_BR) || (opKind == OP_FAR_CALL);

    assign opCycSel = (opKind == OP_CALL_LONG) ? (modeLegacy ? CYC_LONG_LEGACY : CYC_LONG_EXT) :
                      (opKind == OP_CALL_FAST) ? (modeLegacy ? CYC_FAST_LEGACY : CYC_FAST_EXT) :
                      farOp ? CYC_FAR : CYC_OTHER;
    assign opPushSel = (opKind == OP_CALL_LONG || opKind == OP_CALL_FAST || opKind == OP_FAR_CALL)
                       ? (modeLegacy ? PUSH_LEGACY : PUSH_EXT) : 2'h0;

    // Fetch control toward the address generator
    assign fIf.kind = (state_r == ST_BOOT) ? FK_RESET : (irqTake ? FK_IRQ : FK_TABLE);
    assign fIf.idx = irqTake ? {3'h0, irqIdx} : tblIdx;
    assign fIf.load = (state_r == ST_BOOT) || irqTake || tblTake;
    assign fIf.step = (state_r == ST_FETCH0);

    // Next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_BOOT: state_nxt = ST_FETCH0;
            ST_IDLE:
            begin
                if (irqTake || tblTake)
                    state_nxt = ST_FETCH0;
                // far ops refused in legacy mode
                else if (opTake && !(farOp && modeLegacy))
                    state_nxt = ST_EXEC;
            end
            ST_FETCH0: state_nxt = ST_FETCH1;
            ST_FETCH1: state_nxt = ST_IDLE;
            ST_EXEC: state_nxt = (cnt_r == 3'h1) ? ST_IDLE : ST_EXEC;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // boot state fetches the reset vector
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= ST_BOOT;
        else if (clkEn)
            state_r <= state_nxt;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            modeReg_r <= MODE_REG_RESET;
        else if (clkEn && modeWrEn)
            modeReg_r <= modeWrData;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 3'h0;
            push_r <= 2'h0;
            cyc_r <= 3'h0;
            fault_r <= 1'b0;
        end
        else if (clkEn)
        begin
            fault_r <= opTake && farOp && modeLegacy;
            if (opTake && !(farOp && modeLegacy))
            begin
                cnt_r <= opCycSel;
                push_r <= opPushSel;
                cyc_r <= opCycSel;
            end
            else if (state_r == ST_EXEC)
                cnt_r <= cnt_r - 3'h1;
        end
    end

    // Fetch capture; handler vector, table entry
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            kind_r <= FK_RESET;
            byte0_r <= 8'h00;
            vecValid_r <= 1'b0;
            tblValid_r <= 1'b0;
            startPc_r <= 14'h0000;
            regBankEn_r <= 1'b0;
            memBankEn_r <= 1'b0;
            tblEntry_r <= 16'h0000;
        end
        else if (clkEn)
        begin
            if (fIf.load)
                kind_r <= fIf.kind;
            if (state_r == ST_FETCH0)
                byte0_r <= romData;
            vecValid_r <= (state_r == ST_FETCH1) && (kind_r != FK_TABLE);
            tblValid_r <= (state_r == ST_FETCH1) && (kind_r == FK_TABLE);
            if (state_r == ST_FETCH1 && kind_r != FK_TABLE)
            begin
                startPc_r <= {byte0_r[5:0], romData};
                regBankEn_r <= byte0_r[VEC_REG_BANK_BIT];
                memBankEn_r <= byte0_r[VEC_MEM_BANK_BIT];
            end
            if (state_r == ST_FETCH1 && kind_r == FK_TABLE)
                tblEntry_r <= {byte0_r, romData};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            subOsc_r <= 1'b0;
        else if (clkEn)
            subOsc_r <= subOscIn;
    end

    // Output drive
    assign modeRdData = modeReg_r;
    assign legacyMode = modeLegacy;
    assign subOscTestBit = subOsc_r;
    assign opReady = (state_r == ST_IDLE) && !irqReq && !tblReq;
    assign opFault = fault_r;
    assign pushBytes = push_r;
    assign opCycles = cyc_r;
    assign opBusy = (state_r == ST_EXEC);
    assign opDone = (state_r == ST_EXEC) && (cnt_r == 3'h1);
    assign romAddr = fIf.addr;
    assign vecValid = vecValid_r;
    assign startPc = startPc_r;
    assign regBankEnFlag = regBankEn_r;
    assign memBankEnFlag = memBankEn_r;
    assign tableValid = tblValid_r;
    assign tableEntry = tblEntry_r;

    a_mode_bit_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
        legacyMode == modeRdData[3])
        else $error("mode output does not follow bit 3");
    a_push_bytes: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && opTake && opKind == OP_CALL_LONG
        |=> pushBytes == ($past(modeLegacy) ? 2'h2 : 2'h3))
        else $error("wrong stack byte count");
    a_far_refused: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && opTake && farOp && modeLegacy |=> opFault && !opBusy)
        else $error("far op ran in legacy mode");
    a_long_call_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && opTake && opKind == OP_CALL_LONG && !modeLegacy
        ##1 clkEn [*4] |-> opDone && $past(opBusy, 3) && !$past(opDone, 1))
        else $error("extended long call not four cycles");
    a_fast_call_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && opTake && opKind == OP_CALL_FAST && modeLegacy
        ##1 clkEn ##1 clkEn |-> opDone)
        else $error("legacy fast call not two cycles");
    a_reset_mode: assert property (@(posedge sys_clk)
        $rose(rst_n) |-> modeRdData == MODE_REG_RESET)
        else $error("mode register not legacy after reset");
    a_write_whole: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && modeWrEn |=> modeRdData == $past(modeWrData))
        else $error("mode register write lost");
    a_mode_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
        opBusy && $past(opBusy) |-> $stable(pushBytes) && $stable(opCycles))
        else $error("running instruction changed timing");
    a_vec_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && irqTake ##1 clkEn ##1 clkEn |=> vecValid)
        else $error("interrupt vector not delivered");
    a_test_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn |=> subOscTestBit == $past(subOscIn))
        else $error("test bit does not follow pin");
endmodule // ccmv_core

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the call-mode and vector core
// Assumes: Bench drives every pin; program memory is a table of random bytes
// Notes: Each op, fault, vector and table result seen at the outputs is matched in order against a note queue
`timescale 1ns/1ps
module tb_top;
    import ccmv_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    logic modeWrEn = 1'b0;
    logic [3:0] modeWrData = 4'h0;
    logic subOscIn = 1'b0;
    logic opValid = 1'b0;
    ccmv_op_e opKind = OP_OTHER;
    logic irqReq = 1'b0;
    logic [2:0] irqIdx = 3'h0;
    logic tblReq = 1'b0;
    logic [5:0] tblIdx = 6'h0;
    logic [7:0] romData;
    logic [3:0] modeRdData;
    logic legacyMode, subOscTestBit, opReady, opFault, opBusy, opDone;
    logic [1:0] pushBytes;
    logic [2:0] opCycles;
    logic [13:0] romAddr, startPc;
    logic vecValid, regBankEnFlag, memBankEnFlag, tableValid;
    logic [15:0] tableEntry;
    logic [7:0] romMem [0:127];
    logic [31:0] notes [$];
    logic jitter = 1'b0;
    logic lastSub = 1'b0;
    logic subOk = 1'b0;
    logic [2:0] busyCnt = 3'h0;
    integer seed = 32'h287ec8b7;
    int numErrors = 0;
    int testsRun = 0;
    ccmv_op_e kinds [5] = '{OP_OTHER, OP_CALL_LONG, OP_CALL_FAST, OP_FAR_BR, OP_FAR_CALL};

    ccmv_core ccmv_core_i (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
        .modeWrEn(modeWrEn), .modeWrData(modeWrData), .modeRdData(modeRdData),
        .legacyMode(legacyMode), .subOscIn(subOscIn), .subOscTestBit(subOscTestBit),
        .opValid(opValid), .opKind(opKind), .opReady(opReady), .opFault(opFault),
        .pushBytes(pushBytes), .opCycles(opCycles), .opBusy(opBusy), .opDone(opDone),
        .irqReq(irqReq), .irqIdx(irqIdx), .tblReq(tblReq), .tblIdx(tblIdx),
        .romAddr(romAddr), .romData(romData), .vecValid(vecValid), .startPc(startPc),
        .regBankEnFlag(regBankEnFlag), .memBankEnFlag(memBankEnFlag), .tableValid(tableValid),
        .tableEntry(tableEntry));

    // Program memory answers in the same cycle
    assign romData = romMem[romAddr[6:0]];

    // Clock, 100 ns period
    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end

    // Random pin level and optional clock-enable gaps
    always @(posedge sys_clk)
    begin
        subOscIn <= 1'($random(seed));
        clkEn <= jitter ? ((($random(seed)) & 32'h3) != 0) : 1'b1;
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            numErrors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task note(input logic [31:0] got);
        if (notes.size() == 0)
        begin
            numErrors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, 32'h0);
        end
        else
            check(got, notes.pop_front());
    endtask

    // Result monitor, sampled on enabled edges
    always @(posedge sys_clk)
    begin
        if (!rst_n)
            busyCnt = 3'h0;
        else if (clkEn === 1'b1)
        begin
            if (opBusy === 1'b1)
                busyCnt = busyCnt + 3'h1;
            if (opDone === 1'b1)
            begin
                note({2'd0, 22'h0, pushBytes, opCycles, busyCnt});
                busyCnt = 3'h0;
            end
            if (opFault === 1'b1)
                note(32'h40000000);
            if (vecValid === 1'b1)
                note({2'd2, 14'h0, memBankEnFlag, regBankEnFlag, startPc});
            if (tableValid === 1'b1)
                note({2'd3, 14'h0, tableEntry});
        end
    end

    always @(posedge sys_clk)
    begin
        if (!rst_n)
            subOk <= 1'b0;
        else if (clkEn === 1'b1)
        begin
            if (subOk)
                check({31'h0, subOscTestBit}, {31'h0, lastSub});
            lastSub <= subOscIn;
            subOk <= 1'b1;
        end
    end

    // Fault flag, stack bytes and cycles of one op
    function automatic logic [5:0] expOp(input ccmv_op_e k, input logic leg);
        case (k)
            OP_CALL_LONG: return {1'b0, leg ? PUSH_LEGACY : PUSH_EXT,
                leg ? CYC_LONG_LEGACY : CYC_LONG_EXT};
            OP_CALL_FAST: return {1'b0, leg ? PUSH_LEGACY : PUSH_EXT,
                leg ? CYC_FAST_LEGACY : CYC_FAST_EXT};
            OP_FAR_BR: return leg ? 6'h20 : {3'h0, CYC_FAR};
            OP_FAR_CALL: return leg ? 6'h20 : {1'b0, PUSH_EXT, CYC_FAR};
            default: return {3'h0, CYC_OTHER};
        endcase
    endfunction

    // Vector entry: flags and upper PC, then lower PC
    function automatic logic [31:0] expVec(input logic [13:0] b);
        logic [7:0] b0;
        b0 = romMem[b[6:0]];
        return {2'd2, 14'h0, b0[7], b0[6], b0[5:0], romMem[b[6:0] + 7'h1]};
    endfunction

    task waitDrain;
        for (int i = 0; i < 40 && notes.size() != 0; i++)
            @(negedge sys_clk);
        check(32'(notes.size()), 32'h0);
        repeat (3) @(negedge sys_clk);
    endtask

    task waitEnabled;
        @(negedge sys_clk);
        for (int i = 0; i < 40 && clkEn !== 1'b1; i++)
            @(negedge sys_clk);
    endtask

    task doOp(input ccmv_op_e k, input logic leg);
        logic [5:0] e;
        e = expOp(k, leg);
        if (e[5])
            notes.push_back(32'h40000000);
        else
            notes.push_back({2'd0, 22'h0, e[4:0], e[2:0]});
        @(posedge sys_clk);
        opValid <= 1'b1;
        opKind <= k;
        @(negedge sys_clk);
        for (int i = 0; i < 40 && !(opReady === 1'b1 && clkEn === 1'b1); i++)
            @(negedge sys_clk);
        @(posedge sys_clk);
        opValid <= 1'b0;
        waitDrain;
    endtask

    task modeWr(input logic [3:0] d);
        @(posedge sys_clk);
        modeWrEn <= 1'b1;
        modeWrData <= d;
        waitEnabled;
        @(posedge sys_clk);
        modeWrEn <= 1'b0;
        @(negedge sys_clk);
        check({27'h0, legacyMode, modeRdData}, {27'h0, d[3], d});
    endtask

    task fetch(input logic irq, input logic table_indirect_execute, input logic [5:0] idx);
        logic [13:0] b;
        if (irq && idx < 6'h6)
            notes.push_back(expVec(IRQ_VEC_BASE + {7'h0, idx, 1'b0}));
        else if (!irq && table_indirect_execute && idx < TABLE_COUNT)
        begin
            b = TABLE_BASE + {7'h0, idx, 1'b0};
            notes.push_back({2'd3, 14'h0, romMem[b[6:0]], romMem[b[6:0] + 7'h1]});
        end
        @(posedge sys_clk);
        irqReq <= irq;
        tblReq <= table_indirect_execute;
        irqIdx <= idx[2:0];
        tblIdx <= idx;
        waitEnabled;
        @(posedge sys_clk);
        irqReq <= 1'b0;
        tblReq <= 1'b0;
        waitDrain;
    endtask

    task endTest(input string name);
        $display("test %s done, errors so far %0d", name, numErrors);
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        for (int i = 0; i < 128; i++)
            romMem[i] = 8'($random(seed));
        notes.push_back(expVec(RESET_VEC));
        repeat (6) @(posedge sys_clk);
        check({27'h0, legacyMode, modeRdData}, {27'h0, 1'b1, MODE_REG_RESET});
        rst_n <= 1'b1;
        waitDrain;
        endTest("reset");
        for (int i = 0; i < 5; i++)
            doOp(kinds[i], 1'b1);
        modeWr({3'h0, 1'($random(seed))});
        for (int i = 0; i < 5; i++)
            doOp(kinds[i], 1'b0);
        endTest("modes");
        fork
            doOp(OP_CALL_LONG, 1'b0);
            begin
                repeat (3) @(posedge sys_clk);
                modeWr(4'h8);
            end
        join
        doOp(OP_CALL_LONG, 1'b1);
        endTest("mode change");
        for (int i = 0; i < 8; i++)
            fetch(1'b1, 1'b0, 6'(i));
        for (int i = 0; i < 6; i++)
            fetch(1'b0, 1'b1, (i == 0) ? 6'h0 : (i == 1) ? 6'h2f : (i == 2) ? 6'h30
                : 6'($random(seed)));
        fetch(1'b1, 1'b1, 6'h3);
        endTest("fetch");
        jitter = 1'b1;
        modeWr(4'h0);
        doOp(OP_CALL_LONG, 1'b0);
        fetch(1'b1, 1'b0, 6'h2);
        fetch(1'b0, 1'b1, 6'h5);
        jitter = 1'b0;
        endTest("enable gaps");
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(negedge sys_clk);
        check({27'h0, legacyMode, modeRdData}, {27'h0, 1'b1, MODE_REG_RESET});
        notes.push_back(expVec(RESET_VEC));
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        waitDrain;
        endTest("second reset");
        summarize;
    end

    // Watchdog for a hung handshake
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        numErrors++;
        summarize;
    end
endmodule // tb_top
